//--- hw/tlic_top.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Module collectors feed first-level controller inputs
// - Event sets pending; write one clears
// - Local mask gates each pending bit
// - Separate set-mask and clear-mask write ports
// - Collector holds high request while unmasked pending
// - Controller accepts sixty-four sources
// - Per-source mode picks normal or fast
// - Fast source skips arbitration and result registers
// - Mask blocks normal and fast sources
// - Earliest arrival wins regardless of priority, unless both ages have saturated at 255
// - Same-cycle arrivals: lowest priority value wins
// - Equal priority: lowest port number wins
// - One-hot pending and index agree
// - Normal request low while unmasked grant pending
// - Fast request low while fast source active
module tlic_top
  import tlic_pkg::*;
(
  input  wire logic                           SYS_CLK,
  input  wire logic                           RSTN,
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [TLIC_AW-1:0]             PADDR,
  input  wire logic [31:0]                    PWDATA,
  output var  logic [31:0]                    PRDATA,
  output var  logic                           PREADY,
  output var  logic                           PSLVERR,
  input  wire logic [TLIC_NMOD*TLIC_NLOC-1:0] MOD_EVENT,
  input  wire logic [TLIC_NEXT-1:0]           EXT_SRC_REQ,
  output var  logic                           NORMAL_REQUEST_LOW,
  output var  logic                           FAST_REQUEST_LOW,
  output var  logic                           INT_OUT
);

  logic                  acc;
  logic                  acc_first;
  logic                  wr;
  logic                  rd;
  logic [TLIC_AW-1:0]    wbase;
  logic [63:0]           wdat64;
  logic [31:0]           rdata_d;
  logic                  rerr_d;

  logic [63:0]           mode_q;
  logic [63:0]           mask_q;
  logic [63:0]           soft_q;
  logic [63:0]           pnd_q;
  logic [TLIC_IW-1:0]    index_q;
  tlic_state_t           state_q;
  logic [TLIC_PW-1:0]    prio_q [TLIC_NSRC];
  logic [TLIC_AGEW-1:0]  age_q  [TLIC_NSRC];

  tlic_col_t             col_q   [TLIC_NMOD];
  logic [TLIC_NMOD-1:0]  col_req_q;

  logic [63:0]           src_req;
  logic [63:0]           cand;
  logic                  cand_any;
  logic [TLIC_IW-1:0]    win_idx;
  logic                  fast_act;
  logic                  fast_act_q;
  logic                  pnd_clr;
  logic                  grant_take;

  logic [TLIC_NEVT-1:0]  evt;
  logic [TLIC_NEVT-1:0]  istat_q;
  logic [TLIC_NEVT-1:0]  ien_q;
  logic [TLIC_NEVT-1:0]  istat_clr;

  // APB slave: one wait state, effects at the edge where PREADY is high
  assign acc    = PSEL & PENABLE & PREADY;
  assign acc_first = PSEL & PENABLE & ~PREADY;
  assign wr     = acc & PWRITE;
  assign rd     = acc & ~PWRITE;
  assign wbase  = {PADDR[TLIC_AW-1:3], 3'b000};
  assign wdat64 = PADDR[2] ? {PWDATA, 32'h0000_0000} : {32'h0000_0000, PWDATA};

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= acc_first;
    end
  end

  // Read data holds until the next transfer
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (acc_first) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rdata_d;
    end
  end

  // Error stands only beside ready
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PSLVERR <= 1'b0;
    end else if (acc_first) begin
      PSLVERR <= rerr_d;
    end else begin
      PSLVERR <= 1'b0;
    end
  end

  // Second-level collectors, one per module
  genvar m;
  generate
    for (m = 0; m < TLIC_NMOD; m++) begin : g_col
      localparam logic [11:0] CB = 12'(TLIC_OFF_COL + TLIC_COL_STRIDE * m);
      logic [TLIC_NLOC-1:0] ev;
      logic [TLIC_NLOC-1:0] w1c;
      logic [TLIC_NLOC-1:0] setm;
      logic [TLIC_NLOC-1:0] clrm;
      tlic_col_t            nxt;
      // Each local pulse lasts one cycle and is caught in that cycle
      assign ev   = MOD_EVENT[m*TLIC_NLOC +: TLIC_NLOC];
      assign w1c  = (wr && PADDR == CB + TLIC_COL_PEND) ? PWDATA[TLIC_NLOC-1:0] : '0;
      assign setm = (wr && PADDR == CB + TLIC_COL_SETM) ? PWDATA[TLIC_NLOC-1:0] : '0;
      assign clrm = (wr && PADDR == CB + TLIC_COL_CLRM) ? PWDATA[TLIC_NLOC-1:0] : '0;
      always_comb begin
        nxt.pend = (col_q[m].pend & ~w1c) | ev;
        nxt.mask = (col_q[m].mask | setm) & ~clrm;
      end
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          col_q[m].pend <= '0;
          col_q[m].mask <= TLIC_RST_CMASK;
        end else begin
          col_q[m] <= nxt;
        end
      end
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          col_req_q[m] <= 1'b0;
        end else begin
          col_req_q[m] <= |(col_q[m].pend & ~col_q[m].mask);
        end
      end
    end
  endgenerate

  // Source vector: collectors on the low ports, then other modules, plus software
  assign src_req  = {EXT_SRC_REQ, col_req_q} | soft_q;
  assign cand     = src_req & ~mode_q & ~mask_q;
  assign fast_act = |(src_req & mode_q & ~mask_q);

  // Mode, mask and software request registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= TLIC_RST_MODE;
    end else if (wr && wbase == TLIC_OFF_MODE) begin
      mode_q <= PADDR[2] ? {PWDATA, mode_q[31:0]} : {mode_q[63:32], PWDATA};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_q <= TLIC_RST_MASK;
    end else if (wr && wbase == TLIC_OFF_SETM) begin
      mask_q <= mask_q | wdat64;
    end else if (wr && wbase == TLIC_OFF_CLRM) begin
      mask_q <= mask_q & ~wdat64;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      soft_q <= '0;
    end else if (wr && wbase == TLIC_OFF_SOFT) begin
      soft_q <= PADDR[2] ? {PWDATA, soft_q[31:0]} : {soft_q[63:32], PWDATA};
    end
  end

  // Priority fields and arrival age, one set per source
  genvar i;
  generate
    for (i = 0; i < TLIC_NSRC; i++) begin : g_src
      localparam logic [11:0] PA = 12'(TLIC_OFF_PRIO + 4 * (i / 8));
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          prio_q[i] <= TLIC_RST_PRIO;
        end else if (wr && PADDR == PA) begin
          prio_q[i] <= PWDATA[(i % 8) * TLIC_PW +: TLIC_PW];
        end
      end
      // Age counts cycles since the request arrived, saturating at 255; equal age below 255 means same-cycle arrival
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          age_q[i] <= '0;
        end else if (!cand[i]) begin
          age_q[i] <= '0;
        end else if (age_q[i] != TLIC_AGE_MAX) begin
          age_q[i] <= age_q[i] + 8'h01;
        end
      end
    end
  endgenerate

  // Arbiter: oldest first, then lowest priority value, then lowest port
  always_comb begin
    tlic_key_t best;
    tlic_key_t key;
    best     = '0;
    key      = '0;
    cand_any = 1'b0;
    win_idx  = '0;
    for (int k = 0; k < TLIC_NSRC; k++) begin
      key.age      = age_q[k];
      key.prio_inv = ~prio_q[k];
      if (cand[k] && (!cand_any || key > best)) begin
        best     = key;
        win_idx  = TLIC_IW'(k);
        cand_any = 1'b1;
      end
    end
  end

  // Grant is released by writing one to its bit in the pending register
  assign pnd_clr    = wr && wbase == TLIC_OFF_PND && |(pnd_q & wdat64);
  assign grant_take = (state_q == TLIC_ST_IDLE) && cand_any;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= TLIC_ST_IDLE;
    end else begin
      case (state_q)
        TLIC_ST_IDLE: begin
          if (cand_any) begin
            state_q <= TLIC_ST_HELD;
          end
        end
        TLIC_ST_HELD: begin
          if (pnd_clr) begin
            state_q <= TLIC_ST_IDLE;
          end
        end
        default: begin
          state_q <= TLIC_ST_IDLE;
        end
      endcase
    end
  end

  // Both result registers load from the same winner, so they cannot disagree
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pnd_q <= '0;
    end else if (grant_take) begin
      pnd_q <= 64'h0000_0000_0000_0001 << win_idx;
    end else if (state_q != TLIC_ST_HELD || pnd_clr) begin
      pnd_q <= '0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      index_q <= '0;
    end else if (grant_take) begin
      index_q <= win_idx;
    end else if (state_q != TLIC_ST_HELD || pnd_clr) begin
      index_q <= '0;
    end
  end

  // Processor request lines
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      NORMAL_REQUEST_LOW <= 1'b1;
    end else begin
      NORMAL_REQUEST_LOW <= ~|(pnd_q & ~mask_q);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      FAST_REQUEST_LOW <= 1'b1;
    end else begin
      FAST_REQUEST_LOW <= ~fast_act;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fast_act_q <= 1'b0;
    end else begin
      fast_act_q <= fast_act;
    end
  end

  // Event status, cleared by reading; a new event wins over the clear
  assign evt[TLIC_EVT_GRANT] = grant_take;
  assign evt[TLIC_EVT_FAST]  = fast_act & ~fast_act_q;
  assign istat_clr = (rd && PADDR == TLIC_OFF_ISTAT) ? '1 : '0;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~istat_clr) | evt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ien_q <= '0;
    end else if (wr && PADDR == TLIC_OFF_IEN) begin
      ien_q <= PWDATA[TLIC_NEVT-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      INT_OUT <= 1'b0;
    end else begin
      INT_OUT <= |(istat_q & ien_q);
    end
  end

  // Read decode
  always_comb begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    if (wbase == TLIC_OFF_MODE) begin
      rdata_d = PADDR[2] ? mode_q[63:32] : mode_q[31:0];
    end else if (wbase == TLIC_OFF_MASK) begin
      rdata_d = PADDR[2] ? mask_q[63:32] : mask_q[31:0];
    end else if (wbase == TLIC_OFF_SETM || wbase == TLIC_OFF_CLRM) begin
      rdata_d = 32'h0000_0000;
    end else if (wbase == TLIC_OFF_PND) begin
      rdata_d = PADDR[2] ? pnd_q[63:32] : pnd_q[31:0];
    end else if (PADDR == TLIC_OFF_INDEX) begin
      rdata_d = {26'h000_0000, index_q};
    end else if (wbase == TLIC_OFF_SOFT) begin
      rdata_d = PADDR[2] ? soft_q[63:32] : soft_q[31:0];
    end else if (PADDR == TLIC_OFF_ISTAT) begin
      rdata_d = {30'h0000_0000, istat_q};
    end else if (PADDR == TLIC_OFF_IEN) begin
      rdata_d = {30'h0000_0000, ien_q};
    end else if (PADDR >= TLIC_OFF_PRIO && PADDR <= TLIC_OFF_PRIOE && PADDR[1:0] == 2'b00) begin
      for (int j = 0; j < 8; j++) begin
        rdata_d[j*TLIC_PW +: TLIC_PW] = prio_q[{PADDR[4:2], 3'(j)}];
      end
    end else if (PADDR >= TLIC_OFF_COL
                 && PADDR < 12'(TLIC_OFF_COL + TLIC_COL_STRIDE * TLIC_NMOD)
                 && PADDR[1:0] == 2'b00) begin
      for (int c = 0; c < TLIC_NMOD; c++) begin
        if (PADDR[5:4] == 2'(c)) begin
          if (PADDR[3:2] == 2'b00) begin
            rdata_d = {24'h00_0000, col_q[c].pend};
          end else if (PADDR[3:2] == 2'b01) begin
            rdata_d = {24'h00_0000, col_q[c].mask};
          end
        end
      end
    end else begin
      rerr_d = 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- shared/tlic_pkg.sv
`default_nettype none
package tlic_pkg;

  // Sizes
  localparam int TLIC_NSRC  = 64;
  localparam int TLIC_NMOD  = 4;
  localparam int TLIC_NLOC  = 8;
  localparam int TLIC_NEXT  = TLIC_NSRC - TLIC_NMOD;
  localparam int TLIC_PW    = 4;
  localparam int TLIC_IW    = 6;
  localparam int TLIC_AGEW  = 8;
  localparam int TLIC_AW    = 12;
  localparam int TLIC_NEVT  = 2;

  // First-level controller registers, 64-bit ones as low word then high word
  localparam logic [11:0] TLIC_OFF_MODE   = 12'h000;
  localparam logic [11:0] TLIC_OFF_MASK   = 12'h008;
  localparam logic [11:0] TLIC_OFF_SETM   = 12'h010;
  localparam logic [11:0] TLIC_OFF_CLRM   = 12'h018;
  localparam logic [11:0] TLIC_OFF_PND    = 12'h020;
  localparam logic [11:0] TLIC_OFF_INDEX  = 12'h028;
  localparam logic [11:0] TLIC_OFF_SOFT   = 12'h030;
  localparam logic [11:0] TLIC_OFF_ISTAT  = 12'h038;
  localparam logic [11:0] TLIC_OFF_IEN    = 12'h03C;
  localparam logic [11:0] TLIC_OFF_PRIO   = 12'h040;
  localparam logic [11:0] TLIC_OFF_PRIOE  = 12'h05C;

  // Per-module collector windows
  localparam logic [11:0] TLIC_OFF_COL    = 12'h100;
  localparam logic [11:0] TLIC_COL_STRIDE = 12'h010;
  localparam logic [11:0] TLIC_COL_PEND   = 12'h000;
  localparam logic [11:0] TLIC_COL_MASK   = 12'h004;
  localparam logic [11:0] TLIC_COL_SETM   = 12'h008;
  localparam logic [11:0] TLIC_COL_CLRM   = 12'h00C;

  // Event status bit positions
  localparam int TLIC_EVT_GRANT = 0;
  localparam int TLIC_EVT_FAST  = 1;

  // Reset values: all sources blocked, normal mode, priority 0
  localparam logic [63:0] TLIC_RST_MASK  = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] TLIC_RST_MODE  = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  TLIC_RST_CMASK = 8'hFF;
  localparam logic [3:0]  TLIC_RST_PRIO  = 4'h0;
  localparam logic [7:0]  TLIC_AGE_MAX   = 8'hFF;

  typedef enum logic [1:0] {
    TLIC_ST_IDLE = 2'b01,
    TLIC_ST_HELD = 2'b10
  } tlic_state_t;

  typedef struct packed {
    logic [TLIC_NLOC-1:0] pend;
    logic [TLIC_NLOC-1:0] mask;
  } tlic_col_t;

  typedef struct packed {
    logic [TLIC_AGEW-1:0] age;
    logic [TLIC_PW-1:0]   prio_inv;
  } tlic_key_t;

endpackage
`default_nettype wire

//--- verification/tlic_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tlic_checker
  import tlic_pkg::*;
(
  input wire logic                           SYS_CLK,
  input wire logic                           RSTN,
  input wire logic                           PSEL,
  input wire logic                           PENABLE,
  input wire logic                           PWRITE,
  input wire logic [TLIC_AW-1:0]             PADDR,
  input wire logic [31:0]                    PWDATA,
  input wire logic [31:0]                    PRDATA,
  input wire logic                           PREADY,
  input wire logic                           PSLVERR,
  input wire logic [TLIC_NMOD*TLIC_NLOC-1:0] MOD_EVENT,
  input wire logic [TLIC_NEXT-1:0]           EXT_SRC_REQ,
  input wire logic                           NORMAL_REQUEST_LOW,
  input wire logic                           FAST_REQUEST_LOW,
  input wire logic                           INT_OUT
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  property p_rst_out;
    $rose(RSTN) |-> NORMAL_REQUEST_LOW && FAST_REQUEST_LOW && !INT_OUT && !PREADY;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("Outputs not idle after reset");
  property p_wait;
    PSEL && !PENABLE |=> !PREADY ##1 PREADY;
  endproperty
  a_wait: assert property (p_wait) else $error("Ready not after one wait state");
  property p_one;
    PREADY |=> !PREADY;
  endproperty
  a_one: assert property (p_one) else $error("Ready longer than one cycle");
  property p_idle;
    !(PSEL && PENABLE) |=> !PREADY;
  endproperty
  a_idle: assert property (p_idle) else $error("Ready without access");
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  a_err: assert property (p_err) else $error("Error without ready");
  property p_rdata;
    !$stable(PRDATA) |-> PREADY;
  endproperty
  a_rdata: assert property (p_rdata) else $error("Read data moved outside a transfer");
  property p_nrl_hold;
    !NORMAL_REQUEST_LOW && !(PREADY && PWRITE) && !$past(PREADY && PWRITE)
      |=> !NORMAL_REQUEST_LOW;
  endproperty
  a_nrl_hold: assert property (p_nrl_hold) else $error("Normal request dropped alone");
  property p_int_fall;
    $fell(INT_OUT) |-> $past(PREADY) || $past(PREADY, 2) || $past(PREADY, 3);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("Interrupt fell without access");

  c_norm: cover property ($fell(NORMAL_REQUEST_LOW));
  c_fast: cover property ($fell(FAST_REQUEST_LOW));
  c_err: cover property (PSLVERR);
  c_int: cover property ($rose(INT_OUT));
endmodule

bind tlic_top tlic_checker u_chk (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MOD_EVENT(MOD_EVENT), .EXT_SRC_REQ(EXT_SRC_REQ), .NORMAL_REQUEST_LOW(NORMAL_REQUEST_LOW),
  .FAST_REQUEST_LOW(FAST_REQUEST_LOW), .INT_OUT(INT_OUT));
`default_nettype wire

//--- verification/tlic_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlic_periph_model
  import tlic_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic                           fire,
  input  wire logic [4:0]                     fire_idx,
  input  wire logic                           slow,
  input  wire logic [TLIC_NEXT-1:0]           lvl,
  output var  logic [TLIC_NMOD*TLIC_NLOC-1:0] mod_event,
  output var  logic [TLIC_NEXT-1:0]           ext_req
);
  logic                 fire_q;
  logic [TLIC_NEXT-1:0] lvl_q;

  // Local events as single-cycle pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fire_q <= 1'b0;
      mod_event <= '0;
    end else begin
      fire_q <= fire;
      mod_event <= (fire && !fire_q) ? (32'h0000_0001 << fire_idx) : '0;
    end
  end

  // Source levels, one cycle late, or two cycles late when slow
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= '0;
      ext_req <= '0;
    end else begin
      lvl_q <= lvl;
      ext_req <= slow ? lvl_q : lvl;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import tlic_pkg::*;
;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 psel = 1'b0;
  logic                 pen = 1'b0;
  logic                 pwr = 1'b0;
  logic [11:0]          pad = '0;
  logic [31:0]          pwd = '0;
  logic [31:0]          prd, rd;
  logic                 rdy, serr, er, nrl, frl, iout;
  logic                 fire = 1'b0;
  logic                 slow = 1'b0;
  logic [4:0]           fidx = '0;
  logic [TLIC_NEXT-1:0] lvl = '0;
  logic [TLIC_NEXT-1:0] ext;
  logic [31:0]          mev;
  logic [15:0]          lf = 16'h7022;
  logic [15:0]          r;
  logic [31:0]          pw [8];
  logic [3:0]           pa, pb;
  int                   fail_count = 0;
  int                   cmp_count = 0;
  int                   sa, sb, sc, w, l;

  tlic_top dut (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pad), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr),
    .MOD_EVENT(mev), .EXT_SRC_REQ(ext), .NORMAL_REQUEST_LOW(nrl),
    .FAST_REQUEST_LOW(frl), .INT_OUT(iout));
  tlic_periph_model far (.clk(clk), .rstn(rstn), .fire(fire), .fire_idx(fidx),
    .slow(slow), .lvl(lvl), .mod_event(mev), .ext_req(ext));

  always #5 clk = ~clk;

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int win(input int a, input int b, input logic [3:0] qa,
                             input logic [3:0] qb);
    return (qa < qb || (qa == qb && a < b)) ? a : b;
  endfunction
  function automatic logic [11:0] hi(input int s);
    return s >= 32 ? 12'h004 : 12'h000;
  endfunction
  function automatic logic [31:0] bit1(input int s);
    return 32'h0000_0001 << (s % 32);
  endfunction
  task automatic pick(output int s, input int x, input int y);
    do begin
      lf = step(lf);
      s = 4 + lf % 60;
    end while (s == x || s == y);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pad <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1);
    rd = prd;
    er = serr;
    check(n, 2, "one wait state");
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, '0);
    check(rd, e, m);
  endtask
  task automatic setp(input int s, input logic [3:0] p);
    pw[s/8][4*(s%8)+:4] = p;
    apb(1'b1, TLIC_OFF_PRIO + 12'(4 * (s / 8)), pw[s/8]);
  endtask
  // Two sources together, a third arriving while the grant is held
  task automatic arb(input logic tie);
    pick(sa, 0, 0);
    pick(sb, sa, 0);
    pick(sc, sa, sb);
    lf = step(lf);
    pa = lf[3:0];
    pb = tie ? pa : lf[7:4];
    setp(sa, pa);
    setp(sb, pb);
    setp(sc, 4'h0);
    rdc(TLIC_OFF_PRIO + 12'(4 * (sa / 8)), pw[sa/8], "priority");
    lvl[sa-4] <= 1'b1;
    lvl[sb-4] <= 1'b1;
    repeat (3) @(posedge clk);
    w = win(sa, sb, pa, pb);
    l = sa + sb - w;
    rdc(TLIC_OFF_INDEX, w, "index");
    rdc(TLIC_OFF_PND + hi(w), bit1(w), "pending");
    check(nrl, 1'b0, "normal low");
    lvl[sc-4] <= 1'b1;
    lvl[w-4] <= 1'b0;
    apb(1'b1, TLIC_OFF_PND + hi(w), bit1(w));
    repeat (2) @(posedge clk);
    rdc(TLIC_OFF_INDEX, l, "oldest");
    lvl <= '0;
    apb(1'b1, TLIC_OFF_PND + hi(l), bit1(l));
    repeat (3) @(posedge clk);
    check(nrl, 1'b1, "normal released");
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    for (int i = 0; i < 8; i++) pw[i] = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdc(TLIC_OFF_MASK + 12'h004, 32'hFFFF_FFFF, "mask reset");
    rdc(TLIC_OFF_MODE, 32'h0000_0000, "mode reset");
    rdc(TLIC_OFF_COL + TLIC_COL_MASK, 32'h0000_00FF, "local mask reset");
    apb(1'b1, 12'hFF0, 32'h0000_0000);
    check(er, 1'b1, "unmapped");
    lf = step(lf);
    r = lf;
    apb(1'b1, TLIC_OFF_CLRM, {r, r});
    lf = step(lf);
    apb(1'b1, TLIC_OFF_SETM, {16'h0000, lf});
    rdc(TLIC_OFF_MASK, ~{r, r} | {16'h0000, lf}, "set clear mask");
    apb(1'b1, TLIC_OFF_CLRM, 32'hFFFF_FFFF);
    apb(1'b1, TLIC_OFF_CLRM + 12'h004, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) arb(i == 0);
    lf = step(lf);
    sa = lf % 4;
    sb = lf[6:4];
    fidx <= 5'(8 * sa + sb);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(TLIC_OFF_COL + 12'(16 * sa), bit1(sb), "local pending");
    check(nrl, 1'b1, "local masked");
    apb(1'b1, TLIC_OFF_COL + 12'(16 * sa) + TLIC_COL_CLRM, bit1(sb));
    repeat (3) @(posedge clk);
    rdc(TLIC_OFF_INDEX, sa, "module source");
    apb(1'b1, TLIC_OFF_COL + 12'(16 * sa), bit1(sb));
    rdc(TLIC_OFF_COL + 12'(16 * sa), 32'h0000_0000, "local cleared");
    apb(1'b1, TLIC_OFF_COL + 12'(16 * sa) + TLIC_COL_SETM, bit1(sb));
    rdc(TLIC_OFF_COL + 12'(16 * sa) + TLIC_COL_MASK, 32'h0000_00FF, "local set mask");
    apb(1'b1, TLIC_OFF_PND, bit1(sa));
    pick(sc, 0, 0);
    apb(1'b1, TLIC_OFF_MODE + hi(sc), bit1(sc));
    slow <= 1'b1;
    lvl[sc-4] <= 1'b1;
    repeat (4) @(posedge clk);
    check(frl, 1'b0, "fast low");
    check(nrl, 1'b1, "fast skips normal");
    rdc(TLIC_OFF_PND + hi(sc), 32'h0000_0000, "fast no pending");
    apb(1'b1, TLIC_OFF_SETM + hi(sc), bit1(sc));
    repeat (2) @(posedge clk);
    check(frl, 1'b1, "fast masked");
    lvl <= '0;
    apb(1'b1, TLIC_OFF_CLRM + hi(sc), bit1(sc));
    apb(1'b1, TLIC_OFF_MODE + hi(sc), 32'h0000_0000);
    slow <= 1'b0;
    apb(1'b0, TLIC_OFF_ISTAT, 32'h0000_0000);
    apb(1'b1, TLIC_OFF_IEN, 32'h0000_0003);
    rdc(TLIC_OFF_IEN, 32'h0000_0003, "event enable");
    pick(sa, 0, 0);
    apb(1'b1, TLIC_OFF_SOFT + hi(sa), bit1(sa));
    repeat (3) @(posedge clk);
    rdc(TLIC_OFF_INDEX, sa, "soft source");
    check(iout, 1'b1, "event output");
    rdc(TLIC_OFF_ISTAT, 32'h0000_0001, "event status");
    repeat (2) @(posedge clk);
    check(iout, 1'b0, "event cleared");
    apb(1'b1, TLIC_OFF_SOFT + hi(sa), 32'h0000_0000);
    apb(1'b1, TLIC_OFF_PND + hi(sa), bit1(sa));
    rdc(TLIC_OFF_PND + hi(sa), 32'h0000_0000, "released");
    close_out();
  end
endmodule
`default_nettype wire
